// ---- kpsc_keypad_core.sv ----
/*
  Keypad matrix scan controller: configuration registers, row scanning,
  debounce, key record queue and wake/interrupt outputs.
  Assumes a byte-wide register port fed by the serial bus slave, column
  pins pulled up outside, row pins open-drain (driven low when enabled),
  a 32 kHz clock on a pin and sleep/hibernate levels from the power logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "kpsc_params.svh"

// Function
// - a column is scanned only while its column-enable bit is one; reset zero.
// - row pulse width code 00..11 gives 1, 16, 64, 128 clocks; default 128.
// - in sleep each row pulse lasts one 32 kHz period, width code ignored.
// - bit 5 of row control enables hibernate wake; low five bits read zero.
// - a row is driven only while its row-enable bit is one; reset zero.
// - upper nibble sets scan cycles, 0..15, before a record is queued.
// - low four control bits turn columns 0..3 into dedicated keys.
// - bits 7..1 of control low set debounce time, 0..127 ms.
// - bit 0 of control low starts or stops scanning; resets to zero.
// - a record is three matrix slots, function byte, then dedicated byte.
// - slot byte holds row in bits 6..3 and column in bits 2..0.
// - unused slot reports row all ones; slot resets to 0xF8.
// - slot bit 7 is zero for key down, one for key up.
// - function byte has one bit per key, zero down; resets 0xFF.
// - dedicated byte bits 3..0 zero when down, upper bits zero; reset 0x0F.
// - three mask registers hold a key combination that wakes and interrupts.
// - queue holds ten records; when full, flag overflow and refuse new ones.
// - keypad interrupt is raised while a loaded record stays unread.
// - enabled rows are driven low one at a time, others released.
// - with no dedicated key enabled a record is four bytes long.
module kpsc_keypad_core #(
  parameter int MS_CYCLES = `KPSC_MS_NS / `KPSC_CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] col_in,
  output logic [7:0] row_out,
  output logic [7:0] row_oe,
  input wire logic clk32k_in,
  input wire logic sleep_mode,
  input wire logic hibernate_mode,
  output logic key_irq,
  output logic queue_overflow,
  output logic wake_req,
  output logic combo_irq
);
  import kpsc_pkg::*;

  kpsc_state_t s_reg;
  kpsc_state_t s_next;

  function automatic logic [7:0] pw_target(input logic [1:0] code);
    case (code)
      2'b00: pw_target = `KPSC_PW_CODE0;
      2'b01: pw_target = `KPSC_PW_CODE1;
      2'b10: pw_target = `KPSC_PW_CODE2;
      default: pw_target = `KPSC_PW_CODE3;
    endcase
  endfunction

  always_comb
  begin
    logic tick;
    logic pulse_done;
    logic cycle_end;
    logic [7:0] col_live;
    logic [7:0] col_used;
    logic [3:0] ded;
    logic [3:0] dk_now;
    logic [75:0] cur;
    logic [63:0] pend;
    logic [63:0] comb_mask;
    logic [1:0] nslot;
    kpsc_rec_t rec;
    logic any_change;
    logic push;
    logic pop;
    logic [2:0] last_ofs;
    kpsc_rec_t head;
    tick = 1'b0;
    pulse_done = 1'b0;
    cycle_end = 1'b0;
    col_live = 8'h00;
    col_used = 8'h00;
    ded = 4'h0;
    dk_now = 4'h0;
    cur = '0;
    pend = '0;
    comb_mask = '0;
    nslot = 2'd0;
    rec = '0;
    any_change = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    last_ofs = 3'd0;
    head = '0;
    s_next = s_reg;

    // pin synchronisers; the first stage feeds only the second
    s_next.col_a = col_in;
    s_next.col_b = s_reg.col_a;
    s_next.tick_sh = {s_reg.tick_sh[1:0], clk32k_in};
    s_next.col_sync = 2'b00;
    s_next.col_sync2 = 2'b00;
    tick = s_reg.tick_sh[1] & ~s_reg.tick_sh[2];

    ded = s_reg.cnt_ded[3:0];
    col_used = s_reg.col_en & ~{4'h0, ded};
    col_live = ~s_reg.col_b & col_used;
    dk_now = s_reg.col_b[3:0] | ~ded;

    // register writes; result bytes and reserved bits take nothing
    if (reg_wr)
    begin
      case (reg_addr)
        `KPSC_OFS_COL_EN: s_next.col_en = reg_wdata;
        `KPSC_OFS_ROW_PW: s_next.row_pw = reg_wdata & `KPSC_ROW_PW_MASK;
        `KPSC_OFS_ROW_EN: s_next.row_en = reg_wdata;
        `KPSC_OFS_CNT_DED: s_next.cnt_ded = reg_wdata;
        `KPSC_OFS_DB_RUN: s_next.db_run = reg_wdata;
        `KPSC_OFS_COMB0: s_next.comb[0] = reg_wdata;
        `KPSC_OFS_COMB1: s_next.comb[1] = reg_wdata;
        `KPSC_OFS_COMB2: s_next.comb[2] = reg_wdata;
        default: s_next.col_sync = 2'b00;
      endcase
    end

    // scan sequencer: a row-free phase for function keys, then each row
    // the column answer lags the drive by the row flop and two sync flops,
    // so a normal phase ends two clocks after its pulse and samples then
    if (sleep_mode)
      pulse_done = tick;
    else
      pulse_done = (s_reg.pw_cnt ==
                    pw_target(s_reg.row_pw[7:6]) + 8'h02);
    s_next.pw_cnt = pulse_done ? 8'h00 : s_reg.pw_cnt + 8'h01;
    s_next.row_oe = 8'h00;
    s_next.row_out = 8'h00;
    case (s_reg.st)
      SCAN_OFF:
      begin
        s_next.pw_cnt = 8'h00;
        if (s_reg.db_run[0])
          s_next.st = SCAN_FUNC;
      end
      SCAN_FUNC:
      begin
        if (pulse_done)
        begin
          s_next.sf_snap = col_live;
          s_next.row_idx = 3'd0;
          s_next.st = SCAN_ROW;
        end
      end
      SCAN_ROW:
      begin
        // in sleep the row is held for the whole 32 kHz period
        if (sleep_mode || s_reg.pw_cnt < pw_target(s_reg.row_pw[7:6]))
          s_next.row_oe[s_reg.row_idx] =
            s_reg.row_en[s_reg.row_idx];
        if (pulse_done)
        begin
          s_next.snap[{s_reg.row_idx, 3'b000} +: 8] =
            s_reg.row_en[s_reg.row_idx] ? (col_live & ~s_reg.sf_snap) : 8'h00;
          s_next.row_idx = s_reg.row_idx + 3'd1;
          if (s_reg.row_idx == 3'd7)
          begin
            cycle_end = 1'b1;
            s_next.st = SCAN_FUNC;
          end
        end
      end
      default: s_next.st = SCAN_OFF;
    endcase
    if (!s_reg.db_run[0])
    begin
      s_next.st = SCAN_OFF;
      s_next.row_oe = 8'h00;
    end

    // debounce timer in ms, restarted on any change
    if (s_reg.ms_cnt == 16'(MS_CYCLES - 1))
    begin
      s_next.ms_cnt = 16'h0000;
      if (s_reg.ms_elapsed != 7'h7f)
        s_next.ms_elapsed = s_reg.ms_elapsed + 7'd1;
    end
    else
      s_next.ms_cnt = s_reg.ms_cnt + 16'h0001;

    cur = {s_next.snap, s_next.sf_snap, dk_now};
    if (cycle_end)
    begin
      if (cur != s_reg.last)
      begin
        s_next.last = cur;
        s_next.stab_cyc = 4'h0;
        s_next.ms_cnt = 16'h0000;
        s_next.ms_elapsed = 7'd0;
      end
      else if (s_reg.stab_cyc != 4'hf)
        s_next.stab_cyc = s_reg.stab_cyc + 4'h1;
    end

    // build a record of up to three changed matrix keys
    rec[0] = `KPSC_RST_SLOT;
    rec[1] = `KPSC_RST_SLOT;
    rec[2] = `KPSC_RST_SLOT;
    pend = s_reg.last[75:12] ^ s_reg.rep;
    for (int k = 0; k < 64; k++)
    begin
      if (pend[k] && nslot != 2'd3)
      begin
        rec[nslot] = {~s_reg.last[12 + k], 1'b0, 6'(k)};
        nslot = nslot + 2'd1;
      end
    end
    rec[3] = ~s_reg.last[11:4];
    rec[4] = {4'h0, s_reg.last[3:0]};
    any_change = (nslot != 2'd0) || (rec[3] != ~s_reg.rep_sf) ||
                 (s_reg.last[3:0] != s_reg.rep_dk);
    if (cycle_end && cur == s_reg.last && any_change &&
        s_reg.stab_cyc >= s_reg.cnt_ded[7:4] &&
        s_reg.ms_elapsed >= s_reg.db_run[7:1])
    begin
      if (s_reg.fill == `KPSC_QUEUE_DEPTH)
        s_next.overflow = 1'b1;
      else
        push = 1'b1;
    end

    // reading the last byte of the record retires it
    last_ofs = (ded != 4'h0) ? 3'd4 : 3'd3;
    pop = reg_rd && s_reg.fill != 4'h0 &&
          reg_addr == (`KPSC_OFS_SLOT_A + {5'h00, last_ofs});
    if (pop)
    begin
      s_next.rp = (s_reg.rp == `KPSC_QUEUE_DEPTH - 4'h1) ? 4'h0 : s_reg.rp + 4'h1;
      if (!(push || s_next.overflow && !s_reg.overflow))
        s_next.overflow = 1'b0;
    end
    if (push)
    begin
      s_next.queue[s_reg.wp] = rec;
      s_next.wp = (s_reg.wp == `KPSC_QUEUE_DEPTH - 4'h1) ? 4'h0 : s_reg.wp + 4'h1;
      s_next.rep = s_reg.rep;
      for (int j = 0; j < 3; j++)
        if (j < nslot)
          s_next.rep[rec[j][5:0]] = ~rec[j][7];
      s_next.rep_sf = s_reg.last[11:4];
      s_next.rep_dk = s_reg.last[3:0];
    end
    s_next.fill = s_reg.fill + {3'h0, push} - {3'h0, pop};
    s_next.key_irq = (s_next.fill != 4'h0);
    if (push)
      s_next.key_irq = 1'b1;

    // combination: exactly the active mask keys held, nothing else
    for (int j = 0; j < 3; j++)
      if (s_reg.comb[j][7:6] == 2'b00)
        comb_mask[s_reg.comb[j][5:0]] = 1'b1;
    s_next.combo_irq = (comb_mask != '0) && (s_reg.rep == comb_mask);
    s_next.wake = s_next.combo_irq ||
                  (hibernate_mode && s_reg.row_pw[5] && col_live != 8'h00) ||
                  (sleep_mode && push);

    // read data; empty queue shows the reset pattern
    head = s_reg.fill != 4'h0 ? s_reg.queue[s_reg.rp] :
           {`KPSC_RST_DIRECT, `KPSC_RST_FUNC, `KPSC_RST_SLOT,
            `KPSC_RST_SLOT, `KPSC_RST_SLOT};
    s_next.rdata = s_reg.rdata;
    if (reg_rd)
    begin
      case (reg_addr)
        `KPSC_OFS_COL_EN: s_next.rdata = s_reg.col_en;
        `KPSC_OFS_ROW_PW: s_next.rdata = s_reg.row_pw;
        `KPSC_OFS_ROW_EN: s_next.rdata = s_reg.row_en;
        `KPSC_OFS_CNT_DED: s_next.rdata = s_reg.cnt_ded;
        `KPSC_OFS_DB_RUN: s_next.rdata = s_reg.db_run;
        `KPSC_OFS_COMB0: s_next.rdata = s_reg.comb[0];
        `KPSC_OFS_COMB1: s_next.rdata = s_reg.comb[1];
        `KPSC_OFS_COMB2: s_next.rdata = s_reg.comb[2];
        `KPSC_OFS_SLOT_A: s_next.rdata = head[0];
        `KPSC_OFS_SLOT_B: s_next.rdata = head[1];
        `KPSC_OFS_SLOT_C: s_next.rdata = head[2];
        `KPSC_OFS_FUNC: s_next.rdata = head[3];
        `KPSC_OFS_DIRECT: s_next.rdata = head[4] & `KPSC_DIRECT_MASK;
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_reg <= '0;
      s_reg.st <= SCAN_OFF;
      s_reg.col_b <= 8'hff;
      s_reg.col_a <= 8'hff;
      s_reg.col_en <= `KPSC_RST_COL_EN;
      s_reg.row_pw <= `KPSC_RST_ROW_PW;
      s_reg.row_en <= `KPSC_RST_ROW_EN;
      s_reg.cnt_ded <= `KPSC_RST_CNT_DED;
      s_reg.db_run <= `KPSC_RST_DB_RUN;
      s_reg.comb <= {3{`KPSC_RST_COMB}};
      s_reg.last <= 76'h0000_0000_0000_0000_00f;
      s_reg.rep_dk <= 4'hf;
    end
    else
      s_reg <= s_next;
  end

  assign reg_rdata = s_reg.rdata;
  assign row_out = s_reg.row_out;
  assign row_oe = s_reg.row_oe;
  assign key_irq = s_reg.key_irq;
  assign queue_overflow = s_reg.overflow;
  assign wake_req = s_reg.wake;
  assign combo_irq = s_reg.combo_irq;

endmodule
`default_nettype wire

// ---- kpsc_params.svh ----
/*
  Offsets, field positions, reset values and timing counts of the keypad
  scan controller. Definitions only; included by the package and the core.
*/
`ifndef KPSC_PARAMS_SVH
`define KPSC_PARAMS_SVH

`define KPSC_OFS_COL_EN     8'h60
`define KPSC_OFS_ROW_PW     8'h61
`define KPSC_OFS_ROW_EN     8'h62
`define KPSC_OFS_CNT_DED    8'h63
`define KPSC_OFS_DB_RUN     8'h64
`define KPSC_OFS_COMB0      8'h65
`define KPSC_OFS_COMB1      8'h66
`define KPSC_OFS_COMB2      8'h67
`define KPSC_OFS_SLOT_A     8'h68
`define KPSC_OFS_SLOT_B     8'h69
`define KPSC_OFS_SLOT_C     8'h6a
`define KPSC_OFS_FUNC       8'h6b
`define KPSC_OFS_DIRECT     8'h6c

`define KPSC_RST_COL_EN     8'h00
`define KPSC_RST_ROW_PW     8'hc0
`define KPSC_RST_ROW_EN     8'h00
`define KPSC_RST_CNT_DED    8'h00
`define KPSC_RST_DB_RUN     8'h00
`define KPSC_RST_COMB       8'hf8
`define KPSC_RST_SLOT       8'hf8
`define KPSC_RST_FUNC       8'hff
`define KPSC_RST_DIRECT     8'h0f

`define KPSC_ROW_PW_MASK    8'he0
`define KPSC_DIRECT_MASK    8'h0f
`define KPSC_NO_KEY_ROW     4'hf

`define KPSC_PW_CODE0       8'h01
`define KPSC_PW_CODE1       8'h10
`define KPSC_PW_CODE2       8'h40
`define KPSC_PW_CODE3       8'h80

`define KPSC_QUEUE_DEPTH    4'ha
`define KPSC_CLK_PERIOD_NS  25
`define KPSC_MS_NS          1000000

`endif

// ---- kpsc_pkg.sv ----
/*
  Types of the keypad scan controller.
  Assumes kpsc_params.svh is on the include path.
*/
`include "kpsc_params.svh"

package kpsc_pkg;

  typedef enum logic [1:0] {
    SCAN_OFF,
    SCAN_FUNC,
    SCAN_ROW
  } kpsc_scan_st_t;

  typedef logic [4:0][7:0] kpsc_rec_t;

  typedef struct packed {
    logic [1:0] col_sync;
    logic [1:0] col_sync2;
    logic [7:0] col_a;
    logic [7:0] col_b;
    logic [2:0] tick_sh;
    kpsc_scan_st_t st;
    logic [2:0] row_idx;
    logic [7:0] pw_cnt;
    logic [7:0] col_en;
    logic [7:0] row_pw;
    logic [7:0] row_en;
    logic [7:0] cnt_ded;
    logic [7:0] db_run;
    logic [2:0][7:0] comb;
    logic [63:0] snap;
    logic [7:0] sf_snap;
    logic [75:0] last;
    logic [3:0] stab_cyc;
    logic [15:0] ms_cnt;
    logic [6:0] ms_elapsed;
    logic [63:0] rep;
    logic [7:0] rep_sf;
    logic [3:0] rep_dk;
    logic [9:0][39:0] queue;
    logic [3:0] wp;
    logic [3:0] rp;
    logic [3:0] fill;
    logic overflow;
    logic [7:0] rdata;
    logic key_irq;
    logic wake;
    logic combo_irq;
    logic [7:0] row_oe;
    logic [7:0] row_out;
  } kpsc_state_t;

endpackage

// ---- kpsc_keypad_core_sva.sv ----
/* port checker of the keypad scan core.
   assumes a bind into kpsc_keypad_core, single clock domain */
`timescale 1ns/1ps
`default_nettype none
module kpsc_core_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] row_out,
  input wire logic [7:0] row_oe,
  input wire logic sleep_mode,
  input wire logic key_irq,
  input wire logic queue_overflow
);
  logic [1:0] pw_reg;
  logic [7:0] ren_reg;
  logic run_reg;
  logic [7:0] hold_reg;
  logic [7:0] prev_reg;
  logic [7:0] plen;
  // shadows of the config bits, rebuilt from host writes only
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pw_reg <= 2'h3;
      ren_reg <= 8'h00;
      run_reg <= 1'b0;
      hold_reg <= 8'h00;
      prev_reg <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h61)
        pw_reg <= reg_wdata[7:6];
      if (reg_wr && reg_addr == 8'h62)
        ren_reg <= reg_wdata;
      if (reg_wr && reg_addr == 8'h64)
        run_reg <= reg_wdata[0];
      prev_reg <= row_oe;
      if (row_oe == 8'h00)
        hold_reg <= 8'h00;
      else if (row_oe == prev_reg)
        hold_reg <= hold_reg + 8'h01;
      else
        hold_reg <= 8'h01;
    end
  end
  assign plen = pw_reg == 2'h0 ? 8'h01 : pw_reg == 2'h1 ? 8'h10 :
    pw_reg == 2'h2 ? 8'h40 : 8'h80;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence s_read(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_pulse_end;
    prev_reg != 8'h00 && row_oe != prev_reg && run_reg && $past(run_reg)
      && !sleep_mode && !$past(sleep_mode);
  endsequence
  rows_one_hot_a: assert property ($onehot0(row_oe))
    else $error("more than one row driven");
  rows_low_a: assert property (row_out == 8'h00)
    else $error("row output value not low");
  row_enable_a: assert property ((row_oe & ~(ren_reg | $past(ren_reg)
    | $past(ren_reg, 2))) == 8'h00)
    else $error("disabled row driven");
  scan_stop_a: assert property (!run_reg && !$past(run_reg)
    && !$past(run_reg, 2) |-> row_oe == 8'h00)
    else $error("row driven while scan stopped");
  pulse_width_a: assert property (s_pulse_end |-> hold_reg == plen)
    else $error("row pulse length wrong");
  hib_reserved_a: assert property (s_read(8'h61) |=>
    reg_rdata[4:0] == 5'h00)
    else $error("reserved row control bits not zero");
  direct_reserved_a: assert property (s_read(8'h6c) |=>
    reg_rdata[7:4] == 4'h0)
    else $error("reserved direct key bits not zero");
  unmapped_zero_a: assert property (reg_rd && (reg_addr < 8'h60
    || reg_addr > 8'h6c) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  overflow_irq_a: assert property (queue_overflow |-> key_irq)
    else $error("overflow without pending record");
endmodule
bind kpsc_keypad_core kpsc_core_sva u_kpsc_core_sva (.clk(clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .row_out(row_out), .row_oe(row_oe), .sleep_mode(sleep_mode),
  .key_irq(key_irq), .queue_overflow(queue_overflow));
`default_nettype wire

// ---- kpsc_matrix_model.sv ----
/* switch matrix with function and direct keys behind the core.
   assumes row pins only ever pull low, columns pulled up */
`timescale 1ns/1ps
`default_nettype none
module kpsc_matrix_model (
  input wire logic [7:0] row_oe,
  input wire logic [63:0] key_down,
  input wire logic [7:0] func_down,
  input wire logic [3:0] direct_down,
  output logic [7:0] col_in
);
  // released rows float high, so only the driven row can pull a column
  always_comb
  begin
    col_in = ~(func_down | {4'h0, direct_down});
    for (int r = 0; r < 8; r++)
      if (row_oe[r])
        col_in = col_in & ~key_down[r * 8 +: 8];
  end
endmodule
`default_nettype wire

// ---- kpsc_keypad_core_test.sv ----
/* self-checking bench of the keypad scan core.
   assumes the matrix model and the bound port checker */
`timescale 1ns/1ps
`default_nettype none
module kpsc_keypad_core_test;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] col_in;
  logic [7:0] row_out;
  logic [7:0] row_oe;
  logic key_irq;
  logic queue_overflow;
  logic wake_req;
  logic combo_irq;
  logic clk32k_in = 1'b0;
  logic sleep_mode = 1'b0;
  logic [63:0] key_down = 64'h0;
  logic [7:0] func_down = 8'h00;
  logic [3:0] direct_down = 4'h0;
  int err_count = 0;
  int total_checks = 0;
  localparam logic [7:0] RA [11] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64,
    8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h70};
  localparam logic [7:0] RV [11] = '{8'h00, 8'hc0, 8'h00, 8'h00, 8'h00,
    8'hf8, 8'hf8, 8'hf8, 8'hff, 8'h0f, 8'h00};
  localparam logic [7:0] PW [4] = '{8'h01, 8'h10, 8'h40, 8'h80};
  localparam logic [39:0] DN = 40'h2af8_f8ff_00;
  localparam logic [39:0] UP = 40'haaf8_f8ff_00;
  kpsc_keypad_core #(.MS_CYCLES(20)) u_kpsc_keypad_core (.clk(clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .col_in(col_in), .row_out(row_out), .row_oe(row_oe),
    .clk32k_in(clk32k_in), .sleep_mode(sleep_mode), .hibernate_mode(1'b0),
    .key_irq(key_irq), .queue_overflow(queue_overflow),
    .wake_req(wake_req), .combo_irq(combo_irq));
  kpsc_matrix_model u_kpsc_matrix_model (.row_oe(row_oe),
    .key_down(key_down), .func_down(func_down),
    .direct_down(direct_down), .col_in(col_in));
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  // slow clock sped up to 80 core clocks a period to keep runs short
  initial
  begin
    forever #1000 clk32k_in = ~clk32k_in;
  end
  task automatic end_sim;
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    wait_cyc(1);
    reg_wr = 1'b0;
    wait_cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    wait_cyc(1);
    chk($sformatf("reg %h", a), e, reg_rdata);
    reg_rd = 1'b0;
    wait_cyc(1);
  endtask
  // debounce 1 ms, scan count zero, shortest row pulse
  task automatic cfg(input logic [7:0] ded);
    wr(8'h60, 8'hff);
    wr(8'h61, 8'h00);
    wr(8'h62, 8'hff);
    wr(8'h63, ded);
    wr(8'h64, 8'h03);
  endtask
  task automatic rec(input logic [39:0] e, input int n);
    for (int i = 0; i < 3000 && key_irq !== 1'b1; i++)
      wait_cyc(1);
    chk("irq", 8'h01, {7'h0, key_irq});
    for (int i = 0; i < n; i++)
      rd(8'h68 + 8'(i), e[39 - 8 * i -: 8]);
  endtask
  task automatic t_regs;
    for (int i = 0; i < 11; i++)
      rd(RA[i], RV[i]);
    wr(8'h61, 8'hff);
    rd(8'h61, 8'he0);
    wr(8'h6b, 8'h00);
    rd(8'h6b, 8'hff);
    wr(8'h62, 8'h3c);
    rd(8'h62, 8'h3c);
    wr(8'h63, 8'hf5);
    rd(8'h63, 8'hf5);
    wr(8'h64, 8'hfe);
    rd(8'h64, 8'hfe);
  endtask
  task automatic t_keys;
    cfg(8'h00);
    key_down[42] = 1'b1;
    rec(DN, 4);
    chk("irq", 8'h00, {7'h0, key_irq});
    key_down[42] = 1'b0;
    rec(UP, 4);
    cfg(8'h01);
    direct_down[0] = 1'b1;
    rec(40'hf8f8_f8ff_0e, 5);
    direct_down[0] = 1'b0;
    rec(40'hf8f8_f8ff_0f, 5);
    cfg(8'h00);
    func_down[3] = 1'b1;
    rec(40'hf8f8_f8f7_00, 4);
    func_down[3] = 1'b0;
    rec(40'hf8f8_f8ff_00, 4);
  endtask
  task automatic t_combo;
    cfg(8'h00);
    wr(8'h65, 8'h2a);
    key_down[42] = 1'b1;
    rec(DN, 4);
    chk("combo", 8'h01, {7'h0, combo_irq});
    chk("wake", 8'h01, {7'h0, wake_req});
    key_down[42] = 1'b0;
    rec(UP, 4);
    chk("combo", 8'h00, {7'h0, combo_irq});
    wr(8'h65, 8'hf8);
  endtask
  // a disabled column and a stopped scan must both hide the key
  task automatic t_blocked;
    wr(8'h60, 8'hfb);
    key_down[42] = 1'b1;
    wait_cyc(300);
    chk("irq", 8'h00, {7'h0, key_irq});
    key_down[42] = 1'b0;
    wait_cyc(300);
    wr(8'h64, 8'h02);
    wr(8'h60, 8'hff);
    key_down[42] = 1'b1;
    wait_cyc(300);
    chk("irq", 8'h00, {7'h0, key_irq});
    key_down[42] = 1'b0;
  endtask
  task automatic t_overflow;
    cfg(8'h00);
    for (int i = 0; i < 11; i++)
    begin
      key_down[42] = ~key_down[42];
      wait_cyc(200);
    end
    chk("ovf", 8'h01, {7'h0, queue_overflow});
    for (int i = 0; i < 10; i++)
      rec(i[0] ? UP : DN, 4);
    key_down[42] = 1'b0;
    wait_cyc(200);
    for (int i = 0; i < 4 && key_irq === 1'b1; i++)
      rd(8'h6b, 8'hff);
    chk("irq", 8'h00, {7'h0, key_irq});
  endtask
  task automatic t_pulse;
    int n;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h64, 8'h02);
      wr(8'h61, 8'(c << 6));
      wr(8'h64, 8'h03);
      n = 0;
      for (int i = 0; i < 2400 && row_oe[3] !== 1'b1; i++)
        wait_cyc(1);
      while (row_oe[3] === 1'b1 && n < 200)
      begin
        wait_cyc(1);
        n++;
      end
      chk("pulse", PW[c], 8'(n));
    end
    sleep_mode = 1'b1;
    n = 0;
    for (int i = 0; i < 2400 && row_oe[3] !== 1'b1; i++)
      wait_cyc(1);
    while (row_oe[3] === 1'b1 && n < 200)
    begin
      wait_cyc(1);
      n++;
    end
    chk("sleep pulse", 8'h50, 8'(n));
    wr(8'h64, 8'h02);
    sleep_mode = 1'b0;
  endtask
  initial
  begin
    wait_cyc(12);
    nrst = 1'b1;
    t_regs();
    t_keys();
    t_combo();
    t_blocked();
    t_overflow();
    t_pulse();
    end_sim();
  end
  initial
  begin
    #1500000;
    err_count++;
    end_sim();
  end
endmodule
`default_nettype wire
